// [src/acc_core.sv]
// Conversion control for the shared-pin successive-approximation converter.
// Functional notes
// - Selected channel pin is forced to converter input, port logic overridden.
// - Port data and direction writes leave the selected pin unchanged.
// - Port read of the selected pin returns 0.
// - Unselected pins remain ordinary port pins.
// - High reference gives 3FF, low reference gives 000, linear between.
// - Every control register write starts a conversion, unless its channel select is all ones.
// - A conversion takes 16 to 17 converter clocks from its start.
// - Continuous mode overwrites the result after every conversion, read or not; the code refuses new results while the read interlock is held.
// - Continuous mode restarts back to back until its bit is cleared.
// - Without interrupts, done flag sets per conversion, clears on data read.
// - Single mode runs exactly one conversion per control register write.
// - Two justify bits in the clock register pick one of four formats.
// - Left format: eight upper bits high, two lower bits low.
// - Interlocked formats: low read after high, else new results are refused.
// - Right format: two upper bits high, eight lower bits low.
// - Signed left format: as left format with the top bit inverted.
// - Truncation format: eight upper bits in low register, no interlock.
// - With interrupt enabled, request interrupt per conversion; done flag stays 0.
// - Converter runs in wait mode; its interrupt may wake the processor.
// - Stop mode aborts and idles the converter; conversions resume afterwards.
// - Channel select all ones switches the converter off.
// - Data read or control write clears a pending interrupt.
// - High register read freezes the low register until it is read; the code does this in the interlocked formats only, not in truncation format.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module acc_core
	import acc_pkg::*;
#(
	parameter int unsigned NUM_PINS = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [acc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [acc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [acc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [acc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe,
	output logic [NUM_PINS-1:0] analog_sel,
	output logic [4:0] mux_chan,
	output logic conv_power_on,
	output logic sample_hold,
	output logic [acc_pkg::RES_W-1:0] dac_code,
	input wire logic cmp_in,
	input wire logic ext_clk_tick,
	input wire logic wait_mode,
	input wire logic stop_mode,
	output logic conv_irq_req,
	output logic wake_req
);
	import acc_pkg::*;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------

	// Address decode, shared by the read and the write path.
	function automatic acc_sel_t reg_sel(input logic [AXI_ADDR_W-1:0] addr);
		acc_sel_t sel;
		sel = SEL_NONE;
		if (addr[1:0] == 2'b00) begin
			case (addr[AXI_ADDR_W-1:2])
				IDX_SCR[AXI_ADDR_W-3:0]: sel = SEL_SCR;
				IDX_RES_HI[AXI_ADDR_W-3:0]: sel = SEL_RES_HI;
				IDX_RES_LO[AXI_ADDR_W-3:0]: sel = SEL_RES_LO;
				IDX_CLK_CFG[AXI_ADDR_W-3:0]: sel = SEL_CLK_CFG;
				IDX_PORT_DATA[AXI_ADDR_W-3:0]: sel = SEL_PORT_DATA;
				IDX_PORT_DIR[AXI_ADDR_W-3:0]: sel = SEL_PORT_DIR;
				IDX_PORT_PINS[AXI_ADDR_W-3:0]: sel = SEL_PORT_PINS;
				default: sel = SEL_NONE;
			endcase
		end
		return sel;
	endfunction

	// One-hot mask of the pin taken over by the converter; empty when off.
	function automatic logic [NUM_PINS-1:0] chan_mask(input logic [4:0] chan);
		logic [NUM_PINS-1:0] mask;
		mask = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (chan != CHAN_OFF && chan == 5'(i)) begin
				mask[i] = 1'b1;
			end
		end
		return mask;
	endfunction

	// Divider terminal count for the converter clock prescaler.
	function automatic logic [3:0] div_limit(input logic [2:0] div);
		logic [3:0] lim;
		case (div)
			3'h0: lim = DIV_LIM_1;
			3'h1: lim = DIV_LIM_2;
			3'h2: lim = DIV_LIM_4;
			3'h3: lim = DIV_LIM_8;
			default: lim = DIV_LIM_16;
		endcase
		return lim;
	endfunction

	// Result layout for each justification format.
	function automatic acc_result_t fmt_result(input acc_mode_t mode,
			input logic [RES_W-1:0] code);
		acc_result_t res;
		case (mode)
			MODE_LEFT: res = {code[9:2], code[1:0], 6'h00};
			MODE_RIGHT: res = {6'h00, code[9:8], code[7:0]};
			MODE_SIGNED: res = {~code[9], code[8:2], code[1:0], 6'h00};
			MODE_TRUNC: res = {8'h00, code[9:2]};
			default: res = '0;
		endcase
		return res;
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	acc_scr_t scr_reg;
	acc_clk_cfg_t clk_cfg_reg;
	acc_result_t res_reg;
	acc_state_t state_reg;
	acc_mode_t mode;
	acc_sel_t wr_sel;
	acc_sel_t rd_sel;
	logic [7:0] port_data_reg;
	logic [7:0] port_dir_reg;
	logic lock_reg;
	logic irq_reg;
	logic [4:0] tick_cnt_reg;
	logic [RES_W-1:0] sar_reg;
	logic [RES_W-1:0] sar_next;
	logic [3:0] div_cnt_reg;
	logic [3:0] bit_idx;
	logic [4:0] bit_pos;
	logic aw_held_reg;
	logic w_held_reg;
	logic [AXI_ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [7:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic wr_fire;
	logic wr_scr;
	logic rd_fire;
	logic rd_hi;
	logic rd_lo;
	logic data_read;
	logic powered;
	logic src_pulse;
	logic conv_tick;
	logic step;
	logic conv_done;
	logic store_ok;
	logic result_store;
	logic interlocked;
	logic [NUM_PINS-1:0] sel_mask;
	logic [7:0] pin_view;
	logic [7:0] rd_byte;
	acc_scr_t scr_wval;

	// ------------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------------

	// Address and data are latched independently, so either may come first.
	assign s_axi_awready = ~aw_held_reg;
	assign s_axi_wready = ~w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
	assign wr_sel = reg_sel(awaddr_reg);
	assign wr_scr = wr_fire & wstrb0_reg & (wr_sel == SEL_SCR);
	assign scr_wval = wdata_reg;

	// Holding registers for the address and data halves of a write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && !w_held_reg) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer with a slave error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = {24'h00_0000, rdata_reg};
	assign rd_fire = s_axi_arvalid & ~rvalid_reg;
	assign rd_sel = reg_sel(s_axi_araddr);
	assign rd_hi = rd_fire & (rd_sel == SEL_RES_HI);
	assign rd_lo = rd_fire & (rd_sel == SEL_RES_LO);
	assign data_read = rd_hi | rd_lo;

	// Read multiplexer; the converter owned pin reads 0 on the port.
	always_comb begin
		pin_view = 8'h00;
		pin_view[NUM_PINS-1:0] = ((port_dir_reg[NUM_PINS-1:0] & port_data_reg[NUM_PINS-1:0]) |
			(~port_dir_reg[NUM_PINS-1:0] & pin_in)) & ~sel_mask;
		case (rd_sel)
			SEL_SCR: rd_byte = scr_reg;
			SEL_RES_HI: rd_byte = res_reg.hi;
			SEL_RES_LO: rd_byte = res_reg.lo;
			SEL_CLK_CFG: rd_byte = {clk_cfg_reg[7:2], 2'b00};
			SEL_PORT_DATA: rd_byte = port_data_reg;
			SEL_PORT_DIR: rd_byte = port_dir_reg;
			SEL_PORT_PINS: rd_byte = pin_view;
			default: rd_byte = 8'h00;
		endcase
	end

	// Read data is captured on the address handshake and held until taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rresp_reg <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_byte;
			rresp_reg <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------

	// Control fields; the done flag has its own process below.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scr_reg.conv_irq_enable <= SCR_RESET[6];
			scr_reg.continuous_conv_enable <= SCR_RESET[5];
			scr_reg.channel_select_field <= SCR_RESET[4:0];
		end else if (wr_scr) begin
			scr_reg.conv_irq_enable <= scr_wval.conv_irq_enable;
			scr_reg.continuous_conv_enable <= scr_wval.continuous_conv_enable;
			scr_reg.channel_select_field <= scr_wval.channel_select_field;
		end
	end

	// Prescaler, clock source and justification fields.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_cfg_reg <= CLK_CFG_RESET;
		end else if (wr_fire && wstrb0_reg && wr_sel == SEL_CLK_CFG) begin
			clk_cfg_reg <= {wdata_reg[7:2], 2'b00};
		end
	end

	assign mode = acc_mode_t'({clk_cfg_reg.justify_sel_hi, clk_cfg_reg.justify_sel_lo});
	assign interlocked = (mode != MODE_TRUNC);

	// ------------------------------------------------------------------
	// Shared port pins
	// ------------------------------------------------------------------
	assign sel_mask = chan_mask(scr_reg.channel_select_field);
	assign analog_sel = sel_mask;
	assign pin_oe = port_dir_reg[NUM_PINS-1:0] & ~sel_mask;
	assign pin_out = port_data_reg[NUM_PINS-1:0];

	// Port writes keep the old bit of the pin the converter owns.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_data_reg <= PORT_RESET;
			port_dir_reg <= PORT_RESET;
		end else if (wr_fire && wstrb0_reg) begin
			if (wr_sel == SEL_PORT_DATA) begin
				port_data_reg[NUM_PINS-1:0] <= (wdata_reg[NUM_PINS-1:0] & ~sel_mask) |
					(port_data_reg[NUM_PINS-1:0] & sel_mask);
			end
			if (wr_sel == SEL_PORT_DIR) begin
				port_dir_reg[NUM_PINS-1:0] <= (wdata_reg[NUM_PINS-1:0] & ~sel_mask) |
					(port_dir_reg[NUM_PINS-1:0] & sel_mask);
			end
		end
	end

	// ------------------------------------------------------------------
	// Converter clock prescaler
	// ------------------------------------------------------------------
	assign powered = (scr_reg.channel_select_field != CHAN_OFF);
	assign conv_power_on = powered & ~stop_mode;
	assign src_pulse = clk_cfg_reg.conv_clk_source_sel | ext_clk_tick;
	assign conv_tick = src_pulse & (div_cnt_reg == div_limit(clk_cfg_reg.conv_clk_divider_bits));

	// Free running divider; its phase against the start gives the
	// one clock spread in conversion length.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_reg <= 4'h0;
		end else if (!conv_power_on || conv_tick) begin
			div_cnt_reg <= 4'h0;
		end else if (src_pulse) begin
			div_cnt_reg <= div_cnt_reg + 4'h1;
		end
	end

	// ------------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------------
	assign step = (state_reg == ST_RUN) & ~stop_mode & ~wr_scr & conv_tick;
	assign conv_done = step & (tick_cnt_reg == CONV_TICKS - 5'h01);
	assign store_ok = ~interlocked | ~(lock_reg | rd_hi);
	assign result_store = conv_done & store_ok;
	assign sample_hold = (state_reg == ST_RUN) & (tick_cnt_reg < SAMPLE_TICKS);
	assign mux_chan = scr_reg.channel_select_field;

	// Write restarts, continuous mode loops, stop mode parks the sequencer.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			tick_cnt_reg <= 5'h00;
		end else if (wr_scr) begin
			tick_cnt_reg <= 5'h00;
			if (scr_wval.channel_select_field == CHAN_OFF) begin
				state_reg <= ST_IDLE;
			end else if (stop_mode) begin
				state_reg <= ST_HALT;
			end else begin
				state_reg <= ST_RUN;
			end
		end else begin
			case (state_reg)
				ST_IDLE: begin
					tick_cnt_reg <= 5'h00;
				end
				ST_RUN: begin
					if (stop_mode) begin
						state_reg <= ST_HALT;
						tick_cnt_reg <= 5'h00;
					end else if (conv_done) begin
						tick_cnt_reg <= 5'h00;
						if (!scr_reg.continuous_conv_enable) begin
							state_reg <= ST_IDLE;
						end
					end else if (conv_tick) begin
						tick_cnt_reg <= tick_cnt_reg + 5'h01;
					end
				end
				ST_HALT: begin
					if (!stop_mode) begin
						state_reg <= ST_RUN;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Successive approximation: keep the trial bit while the input is at or
	// above the trial level, then try the next lower bit.
	assign bit_pos = tick_cnt_reg - SAMPLE_TICKS;
	assign bit_idx = 4'(RES_W - 1) - bit_pos[3:0];

	always_comb begin
		sar_next = sar_reg;
		if (tick_cnt_reg >= SAMPLE_TICKS) begin
			if (!cmp_in) begin
				sar_next[bit_idx] = 1'b0;
			end
			if (bit_idx != 4'h0) begin
				sar_next[bit_idx - 4'h1] = 1'b1;
			end
		end else if (tick_cnt_reg == SAMPLE_TICKS - 5'h01) begin
			sar_next = SAR_TRIAL_MSB;
		end
	end

	// Trial code register, also the code driven to the comparator level.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sar_reg <= '0;
		end else if (step) begin
			sar_reg <= sar_next;
		end
	end

	assign dac_code = sar_reg;

	// ------------------------------------------------------------------
	// Result registers and read interlock
	// ------------------------------------------------------------------

	// Every stored conversion overwrites the previous result.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_reg <= '0;
		end else if (result_store) begin
			res_reg <= fmt_result(mode, sar_next);
		end
	end

	// A high read in an interlocked format locks out new results until the low byte is read.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_reg <= 1'b0;
		end else if (rd_lo) begin
			lock_reg <= 1'b0;
		end else if (rd_hi && interlocked) begin
			lock_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Completion flag and interrupt request
	// ------------------------------------------------------------------

	// The set wins over a same cycle data read so no completion is missed.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scr_reg.conversion_done_flag <= 1'b0;
		end else if (scr_reg.conv_irq_enable) begin
			scr_reg.conversion_done_flag <= 1'b0;
		end else if (result_store) begin
			scr_reg.conversion_done_flag <= 1'b1;
		end else if (data_read) begin
			scr_reg.conversion_done_flag <= 1'b0;
		end
	end

	// Request level, cleared by a data read or a control write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_reg <= 1'b0;
		end else if (result_store && scr_reg.conv_irq_enable) begin
			irq_reg <= 1'b1;
		end else if (data_read || wr_scr) begin
			irq_reg <= 1'b0;
		end
	end

	assign conv_irq_req = irq_reg;
	// Wait mode leaves the sequencer running, so the request can wake the core.
	assign wake_req = irq_reg & wait_mode;

endmodule // acc_core

// [shared/acc_pkg.sv]
// Package of constants, types and register layout for the converter control block.
package acc_pkg;

	// ------------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------------
	localparam int unsigned AXI_ADDR_W = 12;
	localparam int unsigned AXI_DATA_W = 32;
	localparam int unsigned REG_W = 8;

	// Register indices; the byte address is four times the index.
	localparam logic [11:0] IDX_SCR = 12'h03C;
	localparam logic [11:0] IDX_RES_HI = 12'h03D;
	localparam logic [11:0] IDX_RES_LO = 12'h03E;
	localparam logic [11:0] IDX_CLK_CFG = 12'h03F;
	localparam logic [11:0] IDX_PORT_DATA = 12'h040;
	localparam logic [11:0] IDX_PORT_DIR = 12'h041;
	localparam logic [11:0] IDX_PORT_PINS = 12'h042;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// Converter constants
	// ------------------------------------------------------------------
	localparam int unsigned RES_W = 10;
	localparam logic [7:0] SCR_RESET = 8'h1F;
	localparam logic [7:0] CLK_CFG_RESET = 8'h00;
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam logic [4:0] CHAN_OFF = 5'h1F;
	localparam logic [4:0] CONV_TICKS = 5'h10;
	localparam logic [4:0] SAMPLE_TICKS = 5'h06;
	localparam logic [9:0] SAR_TRIAL_MSB = 10'h200;
	localparam logic [3:0] DIV_LIM_1 = 4'h0;
	localparam logic [3:0] DIV_LIM_2 = 4'h1;
	localparam logic [3:0] DIV_LIM_4 = 4'h3;
	localparam logic [3:0] DIV_LIM_8 = 4'h7;
	localparam logic [3:0] DIV_LIM_16 = 4'hF;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_LEFT = 2'b00,
		MODE_RIGHT = 2'b01,
		MODE_SIGNED = 2'b10,
		MODE_TRUNC = 2'b11
	} acc_mode_t;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} acc_state_t;

	typedef enum logic [2:0] {
		SEL_SCR, SEL_RES_HI, SEL_RES_LO, SEL_CLK_CFG,
		SEL_PORT_DATA, SEL_PORT_DIR, SEL_PORT_PINS, SEL_NONE
	} acc_sel_t;

	typedef struct packed {
		logic conversion_done_flag;
		logic conv_irq_enable;
		logic continuous_conv_enable;
		logic [4:0] channel_select_field;
	} acc_scr_t;

	typedef struct packed {
		logic [2:0] conv_clk_divider_bits;
		logic conv_clk_source_sel;
		logic justify_sel_hi;
		logic justify_sel_lo;
		logic [1:0] unused;
	} acc_clk_cfg_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} acc_result_t;

endpackage

// [test/acc_pins_model.sv]
// Model of the analog sources and outside port pins beside the converter block.
`timescale 1ns/10ps
module acc_pins_model
	import acc_pkg::*;
(
	input logic [9:0] level,
	input logic [7:0] ext_level,
	input logic [7:0] pin_out,
	input logic [7:0] pin_oe,
	input logic [acc_pkg::RES_W-1:0] dac_code,
	output logic [7:0] pin_in,
	output logic cmp_in
);
	// ------------------------------------------------------------------
	// Analog side
	// ------------------------------------------------------------------
	// An ideal comparator, so a finished code equals the applied level exactly.
	assign cmp_in = level >= dac_code;
	// A pin shows what the block drives, else the outside level.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // acc_pins_model

// [test/acc_core_asserts.sv]
// Checker of port-level behaviour for the converter control block.
`timescale 1ns/10ps
module acc_core_asserts
	import acc_pkg::*;
#(
	parameter int unsigned NUM_PINS = 8
) (
	input logic aclk,
	input logic aresetn,
	input logic [acc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [acc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	input logic [NUM_PINS-1:0] pin_oe,
	input logic [NUM_PINS-1:0] analog_sel,
	input logic [4:0] mux_chan,
	input logic conv_power_on,
	input logic sample_hold,
	input logic wait_mode,
	input logic stop_mode,
	input logic conv_irq_req,
	input logic wake_req
);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	// One clock domain, so clock and reset are given once.
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic ar_go;
	assign ar_go = s_axi_arvalid && s_axi_arready;
	AST_SEL_ONE: assert property (mux_chan < 5'h08 |-> $onehot(analog_sel) && analog_sel[mux_chan[2:0]])
		else $error("selected pin not owned by converter");
	AST_SEL_NONE: assert property (mux_chan >= 5'h08 |-> analog_sel == '0)
		else $error("pin owned with no pin channel");
	AST_OE_MASK: assert property ((pin_oe & analog_sel) == '0)
		else $error("converter pin driven by port");
	AST_PORT_READ: assert property (ar_go && s_axi_araddr == (IDX_PORT_PINS << 2)
		|=> (s_axi_rdata[NUM_PINS-1:0] & $past(analog_sel)) == '0)
		else $error("converter pin read not zero");
	AST_POWER: assert property (conv_power_on == (mux_chan != CHAN_OFF && !stop_mode))
		else $error("converter power wrong");
	AST_WAKE: assert property (wake_req == (conv_irq_req && wait_mode))
		else $error("wake request wrong");
	AST_IRQ_RDCLR: assert property (ar_go && (s_axi_araddr == (IDX_RES_HI << 2)
		|| s_axi_araddr == (IDX_RES_LO << 2)) |=> !conv_irq_req)
		else $error("interrupt kept after data read");
	AST_STOP_IDLE: assert property (stop_mode[*3] |-> !sample_hold && !$rose(conv_irq_req))
		else $error("converter active in stop");
	AST_SAMPLE_LEN: assert property ($rose(sample_hold) |-> (sample_hold || !conv_power_on)[*6])
		else $error("sampling phase too short");
endmodule // acc_core_asserts

bind acc_core acc_core_asserts #(.NUM_PINS(NUM_PINS)) acc_core_asserts_i (.*);

// [test/tb.sv]
// Self-checking testbench of the converter control block.
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb;
	import acc_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic wait_mode = 1'h0, stop_mode = 1'h0, ext_clk_tick = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic conv_power_on, sample_hold, cmp_in, conv_irq_req, wake_req;
	logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
	logic [7:0] pin_in, pin_out, pin_oe, analog_sel, rv, ext_level = 8'hFF;
	logic [4:0] mux_chan;
	logic [9:0] dac_code, level = '0;
	int num_errors = 0, total_checks = 0, cyc = 0;

	acc_core acc_core_i (.*);
	acc_pins_model acc_pins_model_i (.*);

	// ------------------------------------------------------------------
	// Clock, timeout and closing report
	// ------------------------------------------------------------------
	initial forever #25 aclk = ~aclk;
	// A hang is cut short well above the fewer than one thousand cycles the run needs.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 8000) begin
			num_errors++;
			stop_test();
		end
	end
	task stop_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Waits end on a falling edge so outputs have settled.
	task wt(input int n);
		repeat (n) @(negedge aclk);
	endtask
	// Bus write: address and data offered together, each released when taken.
	task automatic wr(input logic [11:0] i, input logic [7:0] d);
		logic a, w;
		a = 1'h1;
		w = 1'h1;
		@(posedge aclk);
		s_axi_awaddr <= i << 2;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (a || w) begin
			@(negedge aclk);
			a = a && !s_axi_awready;
			w = w && !s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= a;
			s_axi_wvalid <= w;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		last_resp = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'h0;
	endtask
	// Bus read: data and response are taken at the edge that sees rvalid.
	task automatic rd(input logic [11:0] i, output logic [7:0] d);
		@(posedge aclk);
		s_axi_araddr <= i << 2;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'h0;
		do @(negedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata[7:0];
		last_resp = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'h0;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Reset values, pin takeover and an unmapped place; no converter ticks yet.
	task t_ports;
		rd(IDX_SCR, rv);
		`CHK(rv, SCR_RESET)
		rd(IDX_CLK_CFG, rv);
		`CHK(rv, CLK_CFG_RESET)
		wr(IDX_PORT_DIR, 8'hFF);
		wr(IDX_PORT_DATA, 8'hA5);
		wr(IDX_SCR, 8'h02);
		wt(1);
		`CHK(analog_sel, 8'h04)
		`CHK(pin_oe, 8'hFB)
		wr(IDX_PORT_DATA, 8'h5A);
		wt(1);
		`CHK(pin_out, 8'h5E)
		rd(IDX_PORT_PINS, rv);
		`CHK(rv, 8'h5A)
		wr(IDX_SCR, 8'h07);
		wt(1);
		`CHK(pin_oe, 8'h7F)
		rd(12'h050, rv);
		`CHK(last_resp, RESP_SLVERR)
	endtask
	// Every format once, with full and zero scale among the levels.
	task automatic t_modes;
		logic [9:0] lv [4] = '{10'h3FF, 10'h000, 10'h2C5, 10'h155};
		logic [9:0] l;
		logic [7:0] h, o;
		for (int m = 0; m < 4; m++) begin
			l = lv[m];
			h = (m == 3) ? 8'h00 : (m == 1) ? {6'h00, l[9:8]} : {l[9] ^ (m == 2), l[8:2]};
			o = (m == 3) ? l[9:2] : (m == 1) ? l[7:0] : {l[1:0], 6'h00};
			wr(IDX_CLK_CFG, {3'h0, 1'h1, 2'(m), 2'h0});
			level <= l;
			wr(IDX_SCR, 8'h02);
			wt(12);
			rd(IDX_SCR, rv);
			`CHK(rv, 8'h02)
			wt(8);
			rd(IDX_SCR, rv);
			`CHK(rv, 8'h82)
			rd(IDX_RES_HI, rv);
			`CHK(rv, h)
			rd(IDX_RES_LO, rv);
			`CHK(rv, o)
			wt(20);
			rd(IDX_SCR, rv);
			`CHK(rv, 8'h02)
		end
	endtask
	// Interlock refusal and freeze, then continuous overwrite.
	task t_lock;
		wr(IDX_CLK_CFG, 8'h10);
		level <= 10'h2C5;
		wr(IDX_SCR, 8'h02);
		wt(20);
		rd(IDX_RES_HI, rv);
		level <= 10'h13A;
		wr(IDX_SCR, 8'h02);
		wt(20);
		rd(IDX_SCR, rv);
		`CHK(rv, 8'h02)
		rd(IDX_RES_LO, rv);
		`CHK(rv, 8'h40)
		rd(IDX_RES_HI, rv);
		`CHK(rv, 8'hB1)
		rd(IDX_RES_LO, rv);
		wr(IDX_SCR, 8'h22);
		wt(20);
		rd(IDX_RES_HI, rv);
		`CHK(rv, 8'h4E)
		level <= 10'h3C3;
		wt(40);
		rd(IDX_RES_LO, rv);
		`CHK(rv, 8'h80)
		wt(40);
		rd(IDX_RES_HI, rv);
		`CHK(rv, 8'hF0)
		rd(IDX_RES_LO, rv);
		`CHK(rv, 8'hC0)
		wr(IDX_SCR, 8'h02);
	endtask
	// Interrupt raised, seen in wait, cleared by a control write and a data read.
	task t_irq;
		wr(IDX_CLK_CFG, 8'h1C);
		level <= 10'h155;
		wr(IDX_SCR, 8'h42);
		wt(20);
		`CHK(conv_irq_req, 1'h1)
		rd(IDX_SCR, rv);
		`CHK(rv, 8'h42)
		wait_mode <= 1'h1;
		wt(1);
		`CHK(wake_req, 1'h1)
		wr(IDX_SCR, 8'h42);
		wt(1);
		`CHK(conv_irq_req, 1'h0)
		wt(20);
		`CHK(conv_irq_req, 1'h1)
		rd(IDX_RES_LO, rv);
		wt(1);
		`CHK(conv_irq_req, 1'h0)
		@(posedge aclk);
		wait_mode <= 1'h0;
	endtask
	// Stop aborts and resumes; the all-ones channel turns the converter off.
	task t_stop;
		wr(IDX_SCR, 8'h02);
		wt(10);
		@(posedge aclk);
		stop_mode <= 1'h1;
		wt(30);
		`CHK(conv_power_on, 1'h0)
		rd(IDX_SCR, rv);
		`CHK(rv, 8'h02)
		stop_mode <= 1'h0;
		wt(25);
		rd(IDX_SCR, rv);
		`CHK(rv, 8'h82)
		rd(IDX_RES_LO, rv);
		`CHK(rv, 8'h55)
		// An outside tick every cycle through the divide-by-two doubles the conversion time.
		wr(IDX_CLK_CFG, 8'h2C);
		ext_clk_tick <= 1'h1;
		wr(IDX_SCR, 8'h02);
		wt(20);
		rd(IDX_SCR, rv);
		`CHK(rv, 8'h02)
		wt(20);
		rd(IDX_SCR, rv);
		`CHK(rv, 8'h82)
		rd(IDX_RES_LO, rv);
		`CHK(rv, 8'h55)
		wr(IDX_SCR, 8'h1F);
		wt(20);
		`CHK(conv_power_on, 1'h0)
		rd(IDX_SCR, rv);
		`CHK(rv, 8'h1F)
	endtask

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		t_ports();
		t_modes();
		t_lock();
		t_irq();
		t_stop();
		stop_test();
	end
endmodule // tb
